//--- design/aercel_top.sv
/*
  correctable error log register bank of a switch port, reached over apb.
  assumes event inputs are synchronous pulses from the link and physical
  layers; sys_rst is the fundamental reset, softRst a hot or link-down reset.
*/
`timescale 1ns/1ps
module aercel_top
  import aercel_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   softRst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   receiverFault,
  input  wire logic                   corruptPacket,
  input  wire logic                   corruptLinkPacket,
  input  wire logic                   replayRollover,
  input  wire logic                   replayTimeout,
  input  wire logic                   advisoryNonfatal,
  input  wire logic                   uncorrStrobe,
  input  wire logic [FIRST_IDX_W-1:0] uncorrIndex,
  input  wire logic [31:0]            uncorrHeader,
  input  wire logic                   uncorrRearm,
  output logic                        corrReport,
  output logic                        crcGenerate,
  output logic                        crcCheck
);

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic        wrEn;
  logic        rdEn;
  logic        hitStatus;
  logic        hitMask;
  logic        hitCtl;
  logic        hitLog;
  logic        hitLock;
  logic        mapped;
  logic [31:0] wdataMasked;
  logic [31:0] strbMask;

  // strobe-gated write data and address hits
  always_comb begin
    strbMask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wdataMasked = strbMask & pwdata;
    hitStatus   = (paddr == CORR_STATUS_OFF);
    hitMask     = (paddr == CORR_MASK_OFF);
    hitCtl      = (paddr == REPORT_CTL_OFF);
    hitLog      = (paddr == HDR_LOG0_OFF);
    hitLock     = (paddr == LOCK_OFF);
    mapped      = hitStatus | hitMask | hitCtl | hitLog | hitLock;
    wrEn        = psel & penable & pwrite;
    rdEn        = psel & ~penable & ~pwrite;   // read setup phase
  end

  // zero-wait slave; unmapped accesses get pslverr
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------------------------------------
  // correctable status flags
  // ----------------------------------------------------------------------
  logic [NUM_EVENTS-1:0] evtVec;
  logic [NUM_EVENTS-1:0] clrVec;
  logic [NUM_EVENTS-1:0] flagVec;
  logic [31:0]           statusWord;

  localparam int EVT_POS [NUM_EVENTS] = '{RECV_FAULT_BIT, CORRUPT_PKT_BIT,
    CORRUPT_LINK_BIT, REPLAY_ROLL_BIT, REPLAY_TMO_BIT, ADVISORY_NF_BIT};

  // event inputs in status-bit order
  assign evtVec = {advisoryNonfatal,
                   replayTimeout,
                   replayRollover,
                   corruptLinkPacket,
                   corruptPacket,
                   receiverFault};

  // one sticky flag per event, cleared by a written one
  for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_flag
    assign clrVec[i] = wrEn & hitStatus & wdataMasked[EVT_POS[i]];
    aercel_sticky_flag u_flag (
      .clk      (clk),
      .powerRst (sys_rst),
      .eventIn  (evtVec[i]),
      .clearIn  (clrVec[i]),
      .flagQ    (flagVec[i])
    );
  end

  // assemble the status word; reserved bits read zero
  always_comb begin
    statusWord = 32'h0000_0000;
    for (int k = 0; k < NUM_EVENTS; k++) begin
      statusWord[EVT_POS[k]] = flagVec[k];
    end
  end

  // ----------------------------------------------------------------------
  // mask, control and lock registers
  // ----------------------------------------------------------------------
  logic [31:0] maskQ;
  logic [31:0] maskD;
  logic        genCapQ;
  logic        genCapD;
  logic        chkCapQ;
  logic        chkCapD;
  logic        genEnQ;
  logic        genEnD;
  logic        chkEnQ;
  logic        chkEnD;
  logic        lockQ;
  logic        lockD;

  // software writes; capability bits only while unlocked
  always_comb begin
    maskD   = maskQ;
    genCapD = genCapQ;
    chkCapD = chkCapQ;
    genEnD  = genEnQ;
    chkEnD  = chkEnQ;
    lockD   = lockQ;
    if (wrEn && hitMask) begin
      maskD = ((maskQ & ~strbMask) | wdataMasked) & CORR_IMPL_MASK;
    end
    if (wrEn && hitCtl && pstrb[0]) begin
      genEnD = pwdata[GEN_ENABLE_BIT];
      if (!lockQ) begin
        genCapD = pwdata[GEN_CAPABLE_BIT];
        chkCapD = pwdata[CHECK_CAPABLE_BIT];
      end
    end
    if (wrEn && hitCtl && pstrb[1]) begin
      chkEnD = pwdata[CHECK_ENABLE_BIT];
    end
    if (wrEn && hitLock && pstrb[0]) begin
      lockD = pwdata[0];
    end
  end

  // sticky fields on power-on reset only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      maskQ  <= CORR_MASK_RST;
      genEnQ <= 1'b0;
      chkEnQ <= 1'b0;
    end else begin
      maskQ  <= maskD;
      genEnQ <= genEnD;
      chkEnQ <= chkEnD;
    end
  end

  // non-sticky fields also return on hot or link-down reset
  always_ff @(posedge clk) begin
    if (sys_rst || softRst) begin
      genCapQ <= GEN_CAPABLE_RST;
      chkCapQ <= CHECK_CAPABLE_RST;
      lockQ   <= 1'b0;
    end else begin
      genCapQ <= genCapD;
      chkCapQ <= chkCapD;
      lockQ   <= lockD;
    end
  end

  // ----------------------------------------------------------------------
  // first error capture
  // ----------------------------------------------------------------------
  logic [FIRST_IDX_W-1:0] firstIdx;
  logic [31:0]            hdrLog;

  aercel_first_err u_first (
    .clk       (clk),
    .powerRst  (sys_rst),
    .errStrobe (uncorrStrobe),
    .errIndex  (uncorrIndex),
    .errHeader (uncorrHeader),
    .rearm     (uncorrRearm),
    .firstIdxQ (firstIdx),
    .hdrLogQ   (hdrLog)
  );

  // ----------------------------------------------------------------------
  // outputs: report pulse, crc enables, read data
  // ----------------------------------------------------------------------
  logic        reportD;
  logic        reportQ;
  logic [31:0] ctlWord;
  logic [31:0] rdataD;
  logic [31:0] prdataD;
  logic [31:0] prdataQ;
  logic [31:0] unmaskedEvt;

  // unmasked event of any kind requests a report next cycle
  always_comb begin
    unmaskedEvt = 32'h0000_0000;
    for (int k = 0; k < NUM_EVENTS; k++) begin
      unmaskedEvt[EVT_POS[k]] = evtVec[k];
    end
    reportD = |(unmaskedEvt & ~maskQ);
    ctlWord = 32'h0000_0000;
    ctlWord[FIRST_IDX_LSB +: FIRST_IDX_W] = firstIdx;
    ctlWord[GEN_CAPABLE_BIT]   = genCapQ;
    ctlWord[GEN_ENABLE_BIT]    = genEnQ;
    ctlWord[CHECK_CAPABLE_BIT] = chkCapQ;
    ctlWord[CHECK_ENABLE_BIT]  = chkEnQ;
    rdataD = 32'h0000_0000;
    if (hitStatus) rdataD = statusWord;
    else if (hitMask) rdataD = maskQ;
    else if (hitCtl) rdataD = ctlWord;
    else if (hitLog) rdataD = hdrLog;
    else if (hitLock) rdataD = {31'h0, lockQ};
    prdataD = 32'h0000_0000;
    if (rdEn) begin
      prdataD = rdataD;
    end
  end

  // report pulse and read data registers
  always_ff @(posedge clk) begin
    if (sys_rst || softRst) begin
      reportQ <= 1'b0;
      prdataQ <= 32'h0000_0000;
    end else begin
      reportQ <= reportD;
      prdataQ <= prdataD;
    end
  end

  assign corrReport  = reportQ;
  assign crcGenerate = genEnQ & genCapQ;
  assign crcCheck    = chkEnQ & chkCapQ;

  // read data caught at the setup edge, shown through the access phase
  assign prdata = prdataQ;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_recv_set;
    @(posedge clk) disable iff (sys_rst) receiverFault |=> flagVec[0];
  endproperty
  a_recv_set: assert property (p_recv_set) else $error("receiver flag not set");

  property p_pkt_set;
    @(posedge clk) disable iff (sys_rst) corruptPacket |=> statusWord[CORRUPT_PKT_BIT];
  endproperty
  a_pkt_set: assert property (p_pkt_set) else $error("packet flag not set");

  property p_link_set;
    @(posedge clk) disable iff (sys_rst) corruptLinkPacket |=> statusWord[CORRUPT_LINK_BIT];
  endproperty
  a_link_set: assert property (p_link_set) else $error("link flag not set");

  property p_roll_set;
    @(posedge clk) disable iff (sys_rst) replayRollover |=> statusWord[REPLAY_ROLL_BIT];
  endproperty
  a_roll_set: assert property (p_roll_set) else $error("rollover flag not set");

  property p_tmo_set;
    @(posedge clk) disable iff (sys_rst) replayTimeout |=> statusWord[REPLAY_TMO_BIT];
  endproperty
  a_tmo_set: assert property (p_tmo_set) else $error("timeout flag not set");

  property p_adv_set;
    @(posedge clk) disable iff (sys_rst) advisoryNonfatal |=> statusWord[ADVISORY_NF_BIT];
  endproperty
  a_adv_set: assert property (p_adv_set) else $error("advisory flag not set");

  property p_masked_quiet;
    @(posedge clk) disable iff (sys_rst || softRst)
      (maskQ == CORR_IMPL_MASK) |=> !corrReport;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked report");

  property p_mask_rst;
    @(posedge clk) $fell(sys_rst) |-> maskQ == CORR_MASK_RST;
  endproperty
  a_mask_rst: assert property (p_mask_rst) else $error("mask reset wrong");

  property p_sticky_hold;
    @(posedge clk) disable iff (sys_rst)
      (softRst && !(|evtVec) && !(wrEn && hitStatus)) |=> $stable(statusWord);
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky lost");

  property p_zero_clear;
    @(posedge clk) disable iff (sys_rst)
      (wrEn && hitStatus && pwdata == 32'h0000_0000 && pstrb == 4'hF) |=>
        ((statusWord & $past(statusWord)) == $past(statusWord));
  endproperty
  a_zero_clear: assert property (p_zero_clear) else $error("zero write cleared");

endmodule

//--- design/aercel_pkg.sv
/*
  package for the correctable error log block: register offsets, field positions,
  reset values and the event encoding.
  assumes a 32-bit apb slave with word-aligned registers.
*/
package aercel_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] CORR_STATUS_OFF = 12'h110;
  localparam logic [11:0] CORR_MASK_OFF   = 12'h114;
  localparam logic [11:0] REPORT_CTL_OFF  = 12'h118;
  localparam logic [11:0] HDR_LOG0_OFF    = 12'h11C;
  localparam logic [11:0] LOCK_OFF        = 12'h130;

  // ----------------------------------------------------------------------
  // status and mask field positions
  // ----------------------------------------------------------------------
  localparam int RECV_FAULT_BIT   = 0;
  localparam int CORRUPT_PKT_BIT  = 6;
  localparam int CORRUPT_LINK_BIT = 7;
  localparam int REPLAY_ROLL_BIT  = 8;
  localparam int REPLAY_TMO_BIT   = 12;
  localparam int ADVISORY_NF_BIT  = 13;

  // implemented status bits, all others reserved
  localparam logic [31:0] CORR_IMPL_MASK = 32'h0000_31C1;
  localparam logic [31:0] CORR_MASK_RST  = 32'h0000_2000;

  // ----------------------------------------------------------------------
  // control field positions and reset values
  // ----------------------------------------------------------------------
  localparam int FIRST_IDX_LSB      = 0;
  localparam int FIRST_IDX_W        = 5;
  localparam int GEN_CAPABLE_BIT    = 5;
  localparam int GEN_ENABLE_BIT     = 6;
  localparam int CHECK_CAPABLE_BIT  = 7;
  localparam int CHECK_ENABLE_BIT   = 8;
  localparam logic GEN_CAPABLE_RST   = 1'b1;
  localparam logic CHECK_CAPABLE_RST = 1'b1;
  localparam logic [31:0] HDR_LOG_RST = 32'h0000_0000;
  localparam int NUM_EVENTS = 6;

endpackage

//--- design/aercel_sticky_flag.sv
/*
  one sticky write-one-to-clear status flag.
  assumes the event input is a one-cycle or level pulse in the clk domain.
*/
`timescale 1ns/1ps
module aercel_sticky_flag (
  input  wire logic clk,
  input  wire logic powerRst,
  input  wire logic eventIn,
  input  wire logic clearIn,
  output logic      flagQ
);

  logic flagD;

  // set wins over a clear in the same cycle
  always_comb begin
    flagD = flagQ;
    if (clearIn) begin
      flagD = 1'b0;
    end
    if (eventIn) begin
      flagD = 1'b1;
    end
  end

  // only power-on reset returns the flag to zero
  always_ff @(posedge clk) begin
    if (powerRst) begin
      flagQ <= 1'b0;
    end else begin
      flagQ <= flagD;
    end
  end

endmodule

//--- design/aercel_first_err.sv
/*
  first uncorrectable error capture: pointer and first header word.
  assumes the uncorrectable logic presents index and header with a strobe,
  and re-arms capture with a one-cycle rearm pulse once its status clears.
*/
`timescale 1ns/1ps
module aercel_first_err
  import aercel_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   powerRst,
  input  wire logic                   errStrobe,
  input  wire logic [FIRST_IDX_W-1:0] errIndex,
  input  wire logic [31:0]            errHeader,
  input  wire logic                   rearm,
  output logic [FIRST_IDX_W-1:0]      firstIdxQ,
  output logic [31:0]                 hdrLogQ
);

  logic                   heldQ;
  logic                   heldD;
  logic [FIRST_IDX_W-1:0] firstIdxD;
  logic [31:0]            hdrLogD;

  // capture only the first report until re-armed
  always_comb begin
    heldD     = heldQ;
    firstIdxD = firstIdxQ;
    hdrLogD   = hdrLogQ;
    if (rearm) begin
      heldD = 1'b0;
    end
    if (errStrobe && (!heldQ || rearm)) begin
      heldD     = 1'b1;
      firstIdxD = errIndex;
      hdrLogD   = errHeader;
    end
  end

  // sticky: power-on reset only
  always_ff @(posedge clk) begin
    if (powerRst) begin
      heldQ     <= 1'b0;
      firstIdxQ <= '0;
      hdrLogQ   <= HDR_LOG_RST;
    end else begin
      heldQ     <= heldD;
      firstIdxQ <= firstIdxD;
      hdrLogQ   <= hdrLogD;
    end
  end

endmodule

//--- dv/aercel_link_model.sv
/*
  far-side model: link and physical layer event sources, the uncorrectable
  error logic, and a counter of upstream error reports.
  assumes its tasks are called from the clk domain of the bench.
*/
`timescale 1ns/1ps
module aercel_link_model
  import aercel_pkg::*;
(
  input  wire logic                   clk,
  output logic                        receiverFault,
  output logic                        corruptPacket,
  output logic                        corruptLinkPacket,
  output logic                        replayRollover,
  output logic                        replayTimeout,
  output logic                        advisoryNonfatal,
  output logic                        uncorrStrobe,
  output logic [FIRST_IDX_W-1:0]      uncorrIndex,
  output logic [31:0]                 uncorrHeader,
  output logic                        uncorrRearm,
  input  wire logic                   corrReport
);
  logic [5:0]  evQ = '0;
  logic [31:0] hdrQ = '0;
  int          reports = 0;

  // ---------------------------------------------------------------
  // event lines; header shows a changed value outside its strobe
  // ---------------------------------------------------------------
  assign {advisoryNonfatal, replayTimeout, replayRollover,
          corruptLinkPacket, corruptPacket, receiverFault} = evQ;
  assign uncorrHeader = uncorrStrobe ? hdrQ : ~hdrQ;
  initial begin
    uncorrStrobe = 1'b0;
    uncorrIndex = '0;
    uncorrRearm = 1'b0;
  end

  // one-cycle event pulse
  task automatic pulse(input int i);
    @(posedge clk);
    evQ[i] <= 1'b1;
    @(posedge clk);
    evQ[i] <= 1'b0;
  endtask

  // one uncorrectable error report
  task automatic uerr(input logic [4:0] idx, input logic [31:0] h);
    @(posedge clk);
    uncorrStrobe <= 1'b1;
    uncorrIndex <= idx;
    hdrQ <= h;
    @(posedge clk);
    uncorrStrobe <= 1'b0;
  endtask

  // re-arm the first-error capture
  task automatic rearm();
    @(posedge clk);
    uncorrRearm <= 1'b1;
    @(posedge clk);
    uncorrRearm <= 1'b0;
  endtask

  // counts reports sent upstream
  always @(posedge clk) begin
    if (corrReport === 1'b1) reports <= reports + 1;
  end
endmodule

//--- dv/tb_aercel_top.sv
/*
  self-checking bench for the correctable error log: apb master, reference
  model and the link-side model.
  assumes a zero-wait apb slave and event pulses one clock wide.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_aercel_top
  import aercel_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        softRst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata, uncorrHeader;
  logic [4:0]  uncorrIndex;
  logic        pready, pslverr, corrReport, crcGenerate, crcCheck;
  logic        receiverFault, corruptPacket, corruptLinkPacket, replayRollover;
  logic        replayTimeout, advisoryNonfatal, uncorrStrobe, uncorrRearm;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  int          mStat, mMask, mEn, mCap, mLock, mIdx, mHdr, expRep;
  bit          armed;
  logic [31:0] seed = 32'h0001_122D;
  int          bits[6] = '{RECV_FAULT_BIT, CORRUPT_PKT_BIT, CORRUPT_LINK_BIT,
                           REPLAY_ROLL_BIT, REPLAY_TMO_BIT, ADVISORY_NF_BIT};
  logic [11:0] addrs[6] = '{CORR_STATUS_OFF, CORR_MASK_OFF, REPORT_CTL_OFF,
                            HDR_LOG0_OFF, LOCK_OFF, 12'h100};

  // ---------------------------------------------------------------
  // design, far side, clock and timeout
  // ---------------------------------------------------------------
  aercel_top DUT (.clk, .sys_rst, .softRst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .receiverFault, .corruptPacket,
    .corruptLinkPacket, .replayRollover, .replayTimeout, .advisoryNonfatal,
    .uncorrStrobe, .uncorrIndex, .uncorrHeader, .uncorrRearm, .corrReport,
    .crcGenerate, .crcCheck);
  aercel_link_model partner (.clk, .receiverFault, .corruptPacket,
    .corruptLinkPacket, .replayRollover, .replayTimeout, .advisoryNonfatal,
    .uncorrStrobe, .uncorrIndex, .uncorrHeader, .uncorrRearm, .corrReport);
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // reference model
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic bit mapped(input logic [11:0] a);
    return a inside {CORR_STATUS_OFF, CORR_MASK_OFF, REPORT_CTL_OFF, HDR_LOG0_OFF, LOCK_OFF};
  endfunction
  function automatic logic [31:0] expv(input logic [11:0] a);
    case (a)
      CORR_STATUS_OFF: return mStat;
      CORR_MASK_OFF: return mMask;
      REPORT_CTL_OFF: return mCap | mEn | mIdx;
      HDR_LOG0_OFF: return mHdr;
      LOCK_OFF: return mLock;
      default: return 32'h0000_0000;
    endcase
  endfunction
  task automatic model_reset(input bit full);
    mCap = 32'h0000_00A0;
    mLock = 0;
    if (full) begin
      mStat = 0;
      mMask = CORR_MASK_RST;
      mEn = 0;
      mIdx = 0;
      mHdr = 0;
      armed = 1'b1;
    end
  endtask

  // ---------------------------------------------------------------
  // apb master and checks
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r, bm, v;
    logic        e;
    apb(1'b1, a, d, r, e);
    `CHK("wr_err", !mapped(a), e)
    bm = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    v = (expv(a) & ~bm) | (d & bm);
    case (a)
      CORR_STATUS_OFF: mStat = mStat & ~(d & bm);
      CORR_MASK_OFF: mMask = v & CORR_IMPL_MASK;
      REPORT_CTL_OFF: begin
        mEn = v & 32'h0000_0140;
        if (mLock == 0) mCap = v & 32'h0000_00A0;
      end
      LOCK_OFF: mLock = v & 32'h0000_0001;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [11:0] a);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    `CHK("rd_err", !mapped(a), e)
    `CHK("rd_data", expv(a), r)
  endtask
  task automatic rd_all();
    foreach (addrs[k]) rd(addrs[k]);
  endtask
  task automatic chk_out();
    @(negedge clk);
    `CHK("crcGenerate", mEn[6] & mCap[5], crcGenerate)
    `CHK("crcCheck", mEn[8] & mCap[7], crcCheck)
  endtask
  task automatic ev(input int i);
    partner.pulse(i);
    mStat = mStat | (1 << bits[i]);
    if (mMask[bits[i]] == 0) expRep++;
    repeat (2) @(posedge clk);
    `CHK("reports", expRep, partner.reports)
  endtask
  task automatic uerr(input logic [4:0] idx, input logic [31:0] h);
    partner.uerr(idx, h);
    if (armed) begin
      mIdx = idx;
      mHdr = h;
      armed = 1'b0;
    end
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    model_reset(1'b1);
    expRep = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd_all();
    wr(CORR_STATUS_OFF, 32'hFFFF_FFFF);
    rd(CORR_STATUS_OFF);
    for (int i = 0; i < NUM_EVENTS; i++) ev(i);
    rd(CORR_STATUS_OFF);
    wr(CORR_STATUS_OFF, 32'h0000_0000);
    rd(CORR_STATUS_OFF);
    wr(CORR_STATUS_OFF, 32'h0000_2001);
    rd(CORR_STATUS_OFF);
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      wr(CORR_MASK_OFF, seed);
      for (int i = 0; i < NUM_EVENTS; i++) ev(i);
      rd_all();
    end
    wr(CORR_MASK_OFF, 32'h0000_31C1);
    ev(5);
    pstrb <= 4'h1;
    wr(CORR_MASK_OFF, 32'h0000_0000);
    pstrb <= 4'hF;
    rd(CORR_MASK_OFF);
    wr(REPORT_CTL_OFF, 32'hFFFF_FFFF);
    chk_out();
    wr(LOCK_OFF, 32'h0000_0001);
    wr(REPORT_CTL_OFF, 32'h0000_0040);
    rd(REPORT_CTL_OFF);
    wr(LOCK_OFF, 32'h0000_0000);
    wr(REPORT_CTL_OFF, 32'h0000_0140);
    chk_out();
    uerr(5'h0D, seed);
    uerr(5'h04, ~seed);
    rd_all();
    partner.rearm();
    armed = 1'b1;
    seed = lfsr(seed);
    uerr(seed[4:0], seed);
    rd_all();
    ev(0);
    @(posedge clk) softRst <= 1'b1;
    @(posedge clk) softRst <= 1'b0;
    model_reset(1'b0);
    rd_all();
    chk_out();
    @(posedge clk) sys_rst <= 1'b1;
    @(posedge clk) sys_rst <= 1'b0;
    model_reset(1'b1);
    rd_all();
    chk_out();
    report_and_stop();
  end
endmodule
